// [rtl/svt_pkg.sv]
// Shared constants for the sensor video timing block
package svt_pkg;
  // Horizontal timing in pixel periods
  localparam logic [8:0]  H_TOTAL      = 9'h1ca;
  localparam logic [8:0]  H_ACT        = 9'h180;
  localparam logic [8:0]  H_FP         = 9'h009;
  localparam logic [8:0]  H_SYNC       = 9'h020;
  localparam logic [8:0]  H_BP         = 9'h021;
  localparam logic [8:0]  H_HALF       = 9'h0e5;
  // Vertical timing in half-line periods; two fields make one frame
  localparam logic [10:0] V_TOTAL      = 11'h4e2;
  localparam logic [10:0] V_FIELD      = 11'h271;
  localparam logic [10:0] V_F1_FRONT   = 11'h006;
  localparam logic [10:0] V_F1_BACK    = 11'h026;
  localparam logic [10:0] V_F2_FRONT   = 11'h005;
  localparam logic [10:0] V_F2_BACK    = 11'h027;
  localparam logic [10:0] V_SYNC       = 11'h005;
  localparam logic [10:0] V_ACT        = 11'h240;
  localparam logic [10:0] V_F1_VS      = V_F1_FRONT;
  localparam logic [10:0] V_F1_ACT     = V_F1_FRONT + V_SYNC + V_F1_BACK;
  localparam logic [10:0] V_F2_VS      = V_FIELD + V_F2_FRONT;
  localparam logic [10:0] V_F2_ACT     = V_F2_VS + V_SYNC + V_F2_BACK;
  // Frames to wait after a divisor change
  localparam logic [1:0]  STABLE_FRAMES = 2'h2;
  // Default extra line-valid pixel taken from the back porch
  localparam logic [8:0]  H_EXTRA_DEF  = 9'h001;
  localparam logic [7:0]  DATA_RST     = 8'h00;
endpackage : svt_pkg

// [rtl/svt_tick_if.sv]
// Pixel-rate tick bundle between the strobe generator and the timing core
`timescale 1ns/1ps
interface svt_tick_if;
  logic rise;
  logic fall;
  logic phase;
  logic phase_d;
  modport src (output rise, output fall, output phase, output phase_d);
  modport dst (input rise, input fall, input phase, input phase_d);
endinterface : svt_tick_if

// [rtl/svt_strobe_gen.sv]
// Pixel rate divider: toggles the strobe phase every divisor+1 master clocks
`timescale 1ns/1ps
module svt_strobe_gen #(
  parameter int DIV_W = 6
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire logic             i_clk_en,
  input  wire logic [DIV_W-1:0] i_rate_divisor,
  svt_tick_if.src               tk
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic             phase_q;
  logic             tick;

  // Compare with >= so a divisor lowered mid-count cannot strand the counter
  assign tick       = (cnt_q >= i_rate_divisor);
  assign cnt_d      = tick ? '0 : cnt_q + 1'b1;
  assign tk.phase_d = phase_q ^ tick;
  assign tk.phase   = phase_q;
  assign tk.rise    = i_clk_en & tick & ~phase_q;
  assign tk.fall    = i_clk_en & tick & phase_q;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      cnt_q   <= cnt_d;
      phase_q <= tk.phase_d;
    end
  end

  chk_rate_tick_count: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (tk.rise || tk.fall) |-> (cnt_q >= i_rate_divisor) ##1 (cnt_q == '0))
    else $error("Pixel phase toggled before divisor count elapsed");
endmodule : svt_strobe_gen

// [rtl/svt_video_timing.sv]
// Line and frame timing generator with gated, invertible pixel strobe
`timescale 1ns/1ps
// Notes on behaviour
// - Each line lasts 458 pixel periods, 384 of them active pixels.
// - Nine pixel periods of front porch precede horizontal sync.
// - Horizontal sync lasts 32 pixel periods, then 33 periods back porch.
// - A field lasts 312.5 lines with 288 active lines.
// - Field one: 3 lines front equalisation, 19 lines back equalisation.
// - Field two: 2.5 lines front equalisation, 19.5 lines back equalisation.
// - By default data changes on the strobe's falling edge.
// - Default line valid spans 385 pixels; back porch shrinks to 32.
// - With divisor nine or more a short spurious line-valid pulse is allowed.
// - Invert bit set gives the pixel strobe inverted polarity.
// - Gating clear: strobe runs continuously; set: only inside valid pixels.
// - Pixel rate equals master clock over twice the sum of divisor and one.
// - Output timing is stable only two frames after a divisor change.
module svt_video_timing #(
  parameter int         DIV_W   = 6,
  parameter logic [8:0] H_EXTRA = svt_pkg::H_EXTRA_DEF
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire logic             i_clk_en,
  input  wire logic [DIV_W-1:0] i_rate_divisor,
  input  wire logic             i_strobe_polarity_invert,
  input  wire logic             i_strobe_gating_select,
  input  wire logic             i_external_frame_sync_in,
  input  wire logic [7:0]       i_pixel_data,
  output logic                  o_pixel_strobe,
  output logic                  o_line_valid,
  output logic                  o_hsync,
  output logic                  o_vsync,
  output logic                  o_field,
  output logic [7:0]            o_pixel_data,
  output logic                  o_timing_stable
);
  localparam logic [8:0] ACT_W = svt_pkg::H_ACT + H_EXTRA;
  localparam logic [8:0] HS_LO = ACT_W + svt_pkg::H_FP;
  localparam logic [8:0] HS_HI = HS_LO + svt_pkg::H_SYNC;

  if (DIV_W < 1 || DIV_W > 8)
  begin : g_bad_div
    $error("DIV_W must lie in 1..8");
  end
  if (H_EXTRA > 9'h001)
  begin : g_bad_extra
    $error("H_EXTRA must be 0 or 1");
  end

  svt_tick_if tk ();

  svt_strobe_gen #(
    .DIV_W (DIV_W)
  ) u_strobe_gen (
    .i_ref_clk      (i_ref_clk),
    .i_reset        (i_reset),
    .i_clk_en       (i_clk_en),
    .i_rate_divisor (i_rate_divisor),
    .tk             (tk.src)
  );

  logic [8:0]       h_q;
  logic [8:0]       h_d;
  logic [10:0]      v_q;
  logic [10:0]      v_d;
  logic             fs_prev_q;
  logic [DIV_W-1:0] div_prev_q;
  logic [1:0]       stab_cnt_q;
  logic [1:0]       stab_cnt_d;
  logic             fs_edge;
  logic             h_last;
  logic             half_step;
  logic             v_last;
  logic             lv_win;
  logic             hs_win;
  logic             vs_win;
  logic             vact;
  logic [10:0]      v_line;
  logic             lv_d;
  logic             gate_ok;
  logic             div_chg;

  function automatic logic in_span(input logic [10:0] x, input logic [10:0] lo, input logic [10:0] len);
    in_span = (x >= lo) && (x < lo + len);
  endfunction : in_span

  assign fs_edge   = i_external_frame_sync_in & ~fs_prev_q;
  assign h_last    = (h_q == svt_pkg::H_TOTAL - 9'h001);
  assign half_step = h_last || (h_q == svt_pkg::H_HALF - 9'h001);
  assign h_d       = h_last ? 9'h000 : h_q + 9'h001;
  assign v_last    = (v_q == svt_pkg::V_TOTAL - 11'h001);
  assign v_d       = half_step ? (v_last ? 11'h000 : v_q + 11'h001) : v_q;
  assign vs_win    = in_span(v_q, svt_pkg::V_F1_VS, svt_pkg::V_SYNC) || in_span(v_q, svt_pkg::V_F2_VS, svt_pkg::V_SYNC);
  // whole active lines
  // Field one's active span starts mid-line; deciding per line start keeps every line whole,
  // at the cost of its last line running half a line into the next field's blanking.
  assign v_line    = {v_q[10:1], 1'b0};
  assign vact      = in_span(v_line, svt_pkg::V_F1_ACT, svt_pkg::V_ACT) ||
                     in_span(v_line, svt_pkg::V_F2_ACT, svt_pkg::V_ACT);
  assign lv_win    = vact && (h_q < ACT_W);
  assign hs_win    = (h_q >= HS_LO) && (h_q < HS_HI);
  // no spurious pulse
  // This core never glitches line valid; the allowance is not used.
  assign lv_d      = tk.fall ? lv_win : o_line_valid;
  assign gate_ok   = ~i_strobe_gating_select | lv_d;
  assign div_chg   = (i_rate_divisor != div_prev_q);
  assign stab_cnt_d = div_chg ? 2'h0 :
                      (tk.rise && half_step && v_last && stab_cnt_q != svt_pkg::STABLE_FRAMES) ?
                      stab_cnt_q + 2'h1 : stab_cnt_q;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      h_q <= 9'h000;
      v_q <= 11'h000;
    end
    else if (i_clk_en && fs_edge)
    begin
      h_q <= 9'h000;
      v_q <= 11'h000;
    end
    else if (tk.rise)
    begin
      h_q <= h_d;
      v_q <= v_d;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      fs_prev_q       <= 1'b0;
      div_prev_q      <= '0;
      stab_cnt_q      <= 2'h0;
      o_timing_stable <= 1'b0;
    end
    else if (i_clk_en)
    begin
      fs_prev_q       <= i_external_frame_sync_in;
      div_prev_q      <= i_rate_divisor;
      stab_cnt_q      <= stab_cnt_d;
      o_timing_stable <= (stab_cnt_d == svt_pkg::STABLE_FRAMES);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_line_valid <= 1'b0;
      o_hsync      <= 1'b0;
      o_vsync      <= 1'b0;
      o_field      <= 1'b0;
      o_pixel_data <= svt_pkg::DATA_RST;
    end
    else if (tk.fall)
    begin
      o_line_valid <= lv_win;
      o_hsync      <= hs_win;
      o_vsync      <= vs_win;
      o_field      <= (v_q >= svt_pkg::V_FIELD);
      o_pixel_data <= lv_win ? i_pixel_data : svt_pkg::DATA_RST;
    end
  end

  // polarity invert
  // Strobe follows the next phase so its edges line up with the data update.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      o_pixel_strobe <= 1'b0;
    else if (i_clk_en)
      o_pixel_strobe <= (tk.phase_d & gate_ok) ^ i_strobe_polarity_invert;
  end

  // Helper counts per line, checked at each line wrap
  logic [8:0] lv_cnt_q;
  logic [8:0] hs_cnt_q;
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      lv_cnt_q <= 9'h000;
      hs_cnt_q <= 9'h000;
    end
    else if ((i_clk_en && fs_edge) || (tk.rise && h_last))
    begin
      lv_cnt_q <= 9'h000;
      hs_cnt_q <= 9'h000;
    end
    else if (tk.fall)
    begin
      lv_cnt_q <= lv_cnt_q + {8'h00, lv_win};
      hs_cnt_q <= hs_cnt_q + {8'h00, hs_win};
    end
  end

  chk_line_wrap_zero: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (tk.rise && h_last && !(i_clk_en && fs_edge)) |=> (h_q == 9'h000))
    else $error("Line counter did not wrap after 458 pixels");
  chk_lv_width_line: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (tk.rise && h_last && !fs_edge) |-> (lv_cnt_q == 9'h000 || lv_cnt_q == ACT_W))
    else $error("Line valid width per line is wrong");
  chk_hsync_width_line: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (tk.rise && h_last && !fs_edge) |-> (hs_cnt_q == svt_pkg::H_SYNC))
    else $error("Horizontal sync width per line is wrong");
  chk_front_porch_sync: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (tk.rise && h_q == HS_LO - 9'h001 && !fs_edge) |-> !hs_win && !lv_win ##1 hs_win)
    else $error("Sync did not start after the front porch");
  chk_vsync_start_pos: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $rose(vs_win) |-> ($past(v_q) == svt_pkg::V_F1_VS - 11'h001 || $past(v_q) == svt_pkg::V_F2_VS - 11'h001))
    else $error("Vertical sync started at a wrong half line");
  chk_lv_vsync_blank: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (vs_win || hs_win) |-> !lv_win)
    else $error("Line valid window open during sync");
  chk_data_on_fall: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $changed(o_pixel_data) |-> $past(tk.fall))
    else $error("Pixel data changed away from a falling strobe");
  chk_strobe_polarity: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_clk_en && !i_strobe_gating_select) |=> (o_pixel_strobe == (tk.phase ^ $past(i_strobe_polarity_invert))))
    else $error("Free-running strobe has wrong polarity");
  chk_strobe_gated_idle: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_clk_en && i_strobe_gating_select && !lv_d) |=> (o_pixel_strobe == $past(i_strobe_polarity_invert)))
    else $error("Gated strobe toggled outside the valid window");
  chk_stable_clears: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_clk_en && div_chg) |=> !o_timing_stable)
    else $error("Timing reported stable right after a divisor change");
endmodule : svt_video_timing

// [dv/svt_capture_model.sv]
// Host capture model latching pixel bytes on the falling strobe edge
`timescale 1ns/1ps
module svt_capture_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_invert,
  input  wire logic       i_strobe,
  input  wire logic       i_line_valid,
  input  wire logic [7:0] i_data,
  output logic      [9:0] o_count,
  output logic      [7:0] o_byte,
  output logic      [7:0] o_bad
);
  logic       strobe_q;
  logic       lv_q;
  logic [9:0] cnt_q;
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      strobe_q <= 1'b0;
      lv_q     <= 1'b0;
      cnt_q    <= 10'h000;
      o_count  <= 10'h000;
      o_byte   <= 8'h00;
      o_bad    <= 8'h00;
    end
    else
    begin
      strobe_q <= i_strobe;
      lv_q     <= i_line_valid;
      // latch on falling edge of inverted strobe
      if (strobe_q && !i_strobe && i_line_valid)
      begin
        cnt_q  <= cnt_q + 10'h001;
        o_byte <= i_data;
      end
      // Count restarts per line; the finished count is held for the host
      if (i_line_valid && !lv_q)
        cnt_q <= 10'h000;
      if (!i_line_valid && lv_q)
        o_count <= cnt_q;
      // qualifier moves only where the plain strobe falls
      if ((i_line_valid != lv_q) && (i_strobe != i_invert))
        o_bad <= o_bad + 8'h01;
    end
  end
endmodule : svt_capture_model

// [dv/sensor_video_timing_bench.sv]
// Self-checking bench for the video timing generator
`timescale 1ns/1ps
module sensor_video_timing_bench;
  typedef struct {int a; int b; int px;} svt_row_t;
  logic       i_ref_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic [5:0] i_rate_divisor = 6'h00;
  logic       i_strobe_polarity_invert = 1'b1;
  logic       i_clk_en = 1'b1;
  logic       i_strobe_gating_select = 1'b0;
  logic       i_external_frame_sync_in = 1'b0;
  logic [7:0] i_pixel_data = 8'ha5;
  logic       o_pixel_strobe, o_line_valid, o_hsync, o_vsync, o_field, o_timing_stable;
  logic [7:0] o_pixel_data, cap_byte, cap_bad;
  logic [9:0] cap_count;
  logic       hs_q = 1'b0, vs_q = 1'b0, lv_q = 1'b0;
  int         fails = 0, checked = 0, cyc = 0, nlvr = 0, nlvf = 0, nhs = 0, t_hs = 0, t_prev = 0;
  int         n, k, chg;
  int         ev [9] = '{default: -1};
  svt_row_t   rows [8] = '{'{1, 0, 16'h03d4}, '{2, 1, 16'h0479}, '{3, 2, 16'h22e3}, '{5, 4, 16'h0181},
                           '{6, 5, 16'h0009}, '{7, 6, 16'h0020}, '{8, 7, 16'h0020}, '{8, 4, 16'h01ca}};
  svt_video_timing DUT (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
    .i_rate_divisor(i_rate_divisor), .i_strobe_polarity_invert(i_strobe_polarity_invert),
    .i_strobe_gating_select(i_strobe_gating_select), .i_external_frame_sync_in(i_external_frame_sync_in),
    .i_pixel_data(i_pixel_data), .o_pixel_strobe(o_pixel_strobe), .o_line_valid(o_line_valid),
    .o_hsync(o_hsync), .o_vsync(o_vsync), .o_field(o_field), .o_pixel_data(o_pixel_data),
    .o_timing_stable(o_timing_stable));
  svt_capture_model cap (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_invert(i_strobe_polarity_invert),
    .i_strobe(o_pixel_strobe), .i_line_valid(o_line_valid), .i_data(o_pixel_data),
    .o_count(cap_count), .o_byte(cap_byte), .o_bad(cap_bad));
  always #2.5 i_ref_clk = ~i_ref_clk;
  // Edge times in clocks; only the first few events of the frame are kept
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (o_hsync && !hs_q)
    begin
      if (ev[0] < 0) ev[0] = cyc;
      if (nlvf == 2 && ev[6] < 0) ev[6] = cyc;
      t_prev = t_hs;
      t_hs = cyc;
      nhs++;
    end
    if (!o_hsync && hs_q && nlvf == 2 && ev[7] < 0) ev[7] = cyc;
    if (o_vsync && !vs_q && ev[1] < 0) ev[1] = cyc;
    if (!o_vsync && vs_q && ev[2] < 0) ev[2] = cyc;
    if (o_line_valid && !lv_q)
    begin
      if (nlvr < 2) ev[3 + nlvr] = cyc;
      if (nlvr == 2) ev[8] = cyc;
      nlvr++;
    end
    if (!o_line_valid && lv_q)
    begin
      if (nlvf == 1) ev[5] = cyc;
      nlvf++;
    end
    hs_q = o_hsync;
    vs_q = o_vsync;
    lv_q = o_line_valid;
    if (cyc == 32'h0000_ea60)
    begin
      fails++;
      end_of_test();
    end
  end
  task tick(input int c);
    repeat (c) @(posedge i_ref_clk);
    #1;
  endtask : tick
  task compare(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : compare
  task count_toggles(output int c);
    logic s0;
    c = 0;
    repeat (8)
    begin
      s0 = o_pixel_strobe;
      tick(1);
      if (o_pixel_strobe !== s0) c++;
    end
  endtask : count_toggles
  // A wait that runs out counts as a mismatch
  task wait_lv_fall();
    int m;
    int w;
    m = nlvf;
    for (w = 0; w < 2000 && nlvf == m; w++) tick(1);
    if (nlvf == m) fails++;
  endtask : wait_lv_fall
  task end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    tick(20);
    i_reset = 1'b0;
    for (k = 0; k < 50000 && ev[8] < 0; k++) tick(1);
    if (ev[8] < 0) fails++;
    // Pixel period is two clocks at divisor zero
    foreach (rows[r]) compare(ev[rows[r].a] - ev[rows[r].b], 2 * rows[r].px);
    compare(cap_count, 10'h181);
    compare(cap_byte, 8'ha5);
    compare(cap_bad, 8'h00);
    compare(o_field, 1'b0);
    $display("test line and frame timing done");
    wait_lv_fall();
    tick(10);
    i_strobe_gating_select = 1'b1;
    tick(4);
    count_toggles(chg);
    compare(chg, 0);
    compare(o_pixel_strobe, 1);
    compare(o_pixel_data, 8'h00);
    // Gated strobe must still clock every valid pixel of the next line
    wait_lv_fall();
    tick(2);
    compare(cap_count, 10'h181);
    i_strobe_gating_select = 1'b0;
    i_strobe_polarity_invert = 1'b0;
    tick(4);
    count_toggles(chg);
    compare(chg, 8);
    // Clock enable low freezes the divider and the strobe
    i_clk_en = 1'b0;
    count_toggles(chg);
    compare(chg, 0);
    i_clk_en = 1'b1;
    $display("test strobe gating done");
    i_rate_divisor = 6'h02;
    i_external_frame_sync_in = 1'b1;
    tick(8);
    i_external_frame_sync_in = 1'b0;
    compare(o_timing_stable, 0);
    n = nhs;
    for (k = 0; k < 20000 && nhs < n + 3; k++) tick(1);
    if (nhs < n + 3) fails++;
    compare(t_hs - t_prev, 32'h0000_0abc);
    $display("test rate divisor done");
    end_of_test();
  end
endmodule : sensor_video_timing_bench
